// file: pkg/ddr_core_pkg.sv
// constants, pin layouts and state codes of the ddr access core
// What this block does
// - command pins act only on clock rise
// - rise means true up, complement down
// - one access moves eight beats, or four when chopped, two per clock
// - read strobe edges line up with data
// - first write beat on first strobe rise
// - first read beat on first strobe rise
// - row open latches bank and row
// - access latches bank and start column
// - burst walks columns in programmed order
// - bursts of eight and chopped four
// - auto close shuts row after burst
// - banks work independently and concurrently
// - read fixed, chop and full, optional close
// - write fixed, chop and full, optional close
// - top row bit 13 here, 12 for x16
// - self renew and low power modes exist
// - timing assumes delay locked loop on
package ddr_core_pkg;
  localparam int DQ_W = 8;
  localparam int BANK_W = 3;
  localparam int ROW_MSB = 13; // x8 organisation
  localparam int ADDR_W = 14;
  localparam int PIN_W = 22;
  localparam int DAT_W = 11;
  localparam int MEM_AW = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int COL_HI_BIT = 3;
  localparam int ORD_MSB = 2;
  localparam int MR_BL_MSB = 1;
  localparam int MR_BT_BIT = 3;
  localparam int P_CKE = 21;
  localparam int P_CS = 20;
  localparam int P_RAS = 19;
  localparam int P_WE = 17;
  localparam int P_BA_LSB = 14;
  localparam int D_DQS_T = 10;
  localparam int D_DM = 8;
  localparam logic [BANK_W-1:0] MR0_BANK = 3'h0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;
  // latency holds only with the delay locked loop running
  localparam logic [2:0] READ_LAT = 3'h5;
  localparam logic [2:0] RD_WAIT_INIT = READ_LAT - 3'h1;
  // {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_CLOSE = 3'h2;
  localparam logic [2:0] CMD_ROW_OPEN = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h1,
    PWR_LOW = 3'h2,
    PWR_RENEW = 3'h4
  } power_t;
  typedef enum logic [4:0] {
    RD_IDLE = 5'h01,
    RD_WAIT = 5'h02,
    RD_PRE = 5'h04,
    RD_DATA = 5'h08,
    RD_POST = 5'h10
  } rd_state_t;
endpackage

// file: rtl/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  // pointers wrap naturally, so depth must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t q;
  fifo_state_t n;
  logic push;
  logic pop;

  assign in_ready_out = (q.cnt != FULL_CNT);
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out = q.mem[q.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data_in;
      n.wp = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    unique case ({push, pop})
      2'h2: n.cnt = q.cnt + 1'b1;
      2'h1: n.cnt = q.cnt - 1'b1;
      default: n.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else if (clk_en_in) begin
      q <= n;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.cnt == FULL_CNT) |=> (q.cnt <= FULL_CNT))
    else $error("fifo count passed its depth");
endmodule // byte_fifo

// file: rtl/ddr_access_core.sv
// ddr sdram command decode, bank state and data burst engine
`timescale 1ns/1ns
module ddr_access_core (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic diff_clock_true_in,
  input wire logic diff_clock_comp_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [ddr_core_pkg::BANK_W-1:0] ba_in,
  input wire logic [ddr_core_pkg::ADDR_W-1:0] addr_in,
  input wire logic dm_in,
  input wire logic [ddr_core_pkg::DQ_W-1:0] dq_in,
  output logic [ddr_core_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic dqs_true_in,
  input wire logic dqs_comp_in,
  output logic dqs_true_out,
  output logic dqs_comp_out,
  output logic dqs_oe_out
);
  import ddr_core_pkg::*;

  // storage keeps row bit 0 and column bits 3 to 0 only; wider rows alias
  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [1:0] ck_s1;
    logic [1:0] ck_s2;
    logic [1:0] ck_s3;
    logic [DAT_W-1:0] dat_s1;
    logic [DAT_W-1:0] dat_s2;
    logic dqs_prev;
    power_t pwr;
    logic [7:0] bank_open;
    logic [7:0][ROW_MSB:0] open_row;
    logic [1:0] mr_bl;
    logic mr_interleave;
    rd_state_t rd;
    logic [2:0] rd_lat;
    logic [3:0] rd_left;
    logic rd_autoclose;
    logic [BANK_W-1:0] rd_bank;
    logic fetch_busy;
    logic [BANK_W-1:0] fetch_bank;
    logic [1:0] fetch_hi;
    logic [2:0] fetch_start;
    logic [3:0] fetch_idx;
    logic [3:0] fetch_len;
    logic wr_armed;
    logic [BANK_W-1:0] wr_bank;
    logic [1:0] wr_hi;
    logic [2:0] wr_start;
    logic [3:0] wr_idx;
    logic [3:0] wr_len;
    logic wr_autoclose;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic dqs_o;
    logic dqs_c;
    logic dqs_oe;
    logic [(1<<MEM_AW)-1:0][DQ_W-1:0] mem;
  } state_t;

  state_t q;
  state_t n;
  logic ck_rise;
  logic ck_fall;
  logic ck_edge;
  logic dqs_rise;
  logic dqs_edge;
  logic cmd_take;
  logic [2:0] cmd;
  logic [BANK_W-1:0] cmd_ba;
  logic [ADDR_W-1:0] cmd_a;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [DQ_W-1:0] push_data;
  logic [DQ_W-1:0] pop_data;

  // column order inside a burst, shared by read fetch and write capture
  function automatic logic [MEM_AW-1:0] beat_addr(
    input logic [BANK_W-1:0] bank,
    input logic [1:0] hi,
    input logic [2:0] start,
    input logic [2:0] idx,
    input logic intl
  );
    logic [2:0] ord;
    logic [1:0] low;
    low = start[1:0] + idx[1:0];
    ord = intl ? (start ^ idx) : {start[ORD_MSB] ^ idx[ORD_MSB], low};
    return {bank, hi, ord};
  endfunction

  // fixed mode or per-command chop selected by the chop address bit
  function automatic logic [3:0] burst_len(input logic [1:0] bl, input logic chop_n);
    if (bl == BL_OTF) begin
      return chop_n ? BEATS_FULL : BEATS_CHOP;
    end
    return (bl == BL_FIXED4) ? BEATS_CHOP : BEATS_FULL;
  endfunction

  // positive edge needs true rising while complement falls
  assign ck_rise = q.ck_s2[1] & ~q.ck_s2[0] & ~q.ck_s3[1] & q.ck_s3[0];
  assign ck_fall = ~q.ck_s2[1] & q.ck_s2[0] & q.ck_s3[1] & ~q.ck_s3[0];
  assign ck_edge = ck_rise | ck_fall;
  // strobe and data share sync depth, so centring survives
  assign dqs_rise = q.dat_s2[D_DQS_T] & ~q.dqs_prev;
  assign dqs_edge = q.dat_s2[D_DQS_T] ^ q.dqs_prev;
  assign cmd = q.pin_s2[P_RAS:P_WE];
  assign cmd_ba = q.pin_s2[P_BA_LSB +: BANK_W];
  assign cmd_a = q.pin_s2[ADDR_W-1:0];
  // commands are taken on the rise only, never on the fall
  assign cmd_take = ck_rise & ~q.pin_s2[P_CS] & q.pin_s2[P_CKE] & (q.pwr == PWR_ACTIVE);
  assign push_data = q.mem[beat_addr(q.fetch_bank, q.fetch_hi, q.fetch_start,
                                     q.fetch_idx[2:0], q.mr_interleave)];
  // one beat per clock half, so two beats per clock
  assign pop_ready = ((q.rd == RD_PRE) & ck_rise) |
                     ((q.rd == RD_DATA) & ck_edge & (q.rd_left != 4'h0));

  byte_fifo #(
    .WIDTH(DQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_read_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .in_valid_in(q.fetch_busy),
    .in_data_in(push_data),
    .in_ready_out(push_ready),
    .out_valid_out(pop_valid),
    .out_data_out(pop_data),
    .out_ready_in(pop_ready)
  );

  always_comb begin
    n = q;
    n.pin_s1 = {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, ba_in, addr_in};
    n.pin_s2 = q.pin_s1;
    n.ck_s1 = {diff_clock_true_in, diff_clock_comp_in};
    n.ck_s2 = q.ck_s1;
    n.ck_s3 = q.ck_s2;
    n.dat_s1 = {dqs_true_in, dqs_comp_in, dm_in, dq_in};
    n.dat_s2 = q.dat_s1;
    n.dqs_prev = q.dat_s2[D_DQS_T];

    // fetch stalls while the fifo is full
    if (q.fetch_busy && push_ready) begin
      n.fetch_idx = q.fetch_idx + 4'h1;
      if (q.fetch_idx == q.fetch_len - 4'h1) begin
        n.fetch_busy = 1'b0;
      end
    end

    unique case (q.rd)
      RD_IDLE: begin
        n.rd = RD_IDLE;
      end
      RD_WAIT: begin
        if (ck_rise) begin
          if (q.rd_lat == 3'h1) begin
            // preamble: strobe driven low one clock ahead
            n.rd = RD_PRE;
            n.dqs_oe = 1'b1;
            n.dqs_o = 1'b0;
            n.dqs_c = 1'b1;
          end else begin
            n.rd_lat = q.rd_lat - 3'h1;
          end
        end
      end
      RD_PRE: begin
        if (ck_rise) begin
          // first beat leaves with the first strobe rise
          n.rd = RD_DATA;
          n.dq_oe = 1'b1;
          n.dq_o = pop_data;
          n.dqs_o = 1'b1;
          n.dqs_c = 1'b0;
          n.rd_left = q.fetch_len - 4'h1;
        end
      end
      RD_DATA: begin
        if (ck_edge) begin
          if (q.rd_left != 4'h0) begin
            n.dq_o = pop_data;
            n.dqs_o = ~q.dqs_o;
            n.dqs_c = q.dqs_o;
            n.rd_left = q.rd_left - 4'h1;
          end else begin
            // postamble half clock with strobe low, data released
            n.rd = RD_POST;
            n.dq_oe = 1'b0;
            n.dqs_o = 1'b0;
            n.dqs_c = 1'b1;
            if (q.rd_autoclose) begin
              n.bank_open[q.rd_bank] = 1'b0;
            end
          end
        end
      end
      RD_POST: begin
        if (ck_edge) begin
          n.rd = RD_IDLE;
          n.dqs_oe = 1'b0;
        end
      end
      default: begin
        n.rd = RD_IDLE;
        n.dq_oe = 1'b0;
        n.dqs_oe = 1'b0;
      end
    endcase

    // first beat only on a rise, later beats on both edges
    if (q.wr_armed && ((q.wr_idx == 4'h0) ? dqs_rise : dqs_edge)) begin
      if (!q.dat_s2[D_DM]) begin
        n.mem[beat_addr(q.wr_bank, q.wr_hi, q.wr_start, q.wr_idx[2:0],
                        q.mr_interleave)] = q.dat_s2[DQ_W-1:0];
      end
      n.wr_idx = q.wr_idx + 4'h1;
      if (q.wr_idx == q.wr_len - 4'h1) begin
        n.wr_armed = 1'b0;
        if (q.wr_autoclose) begin
          n.bank_open[q.wr_bank] = 1'b0;
        end
      end
    end

    // low power and self renew entered and left by cke
    if (ck_rise) begin
      unique case (q.pwr)
        PWR_ACTIVE: begin
          if (!q.pin_s2[P_CKE]) begin
            n.pwr = (!q.pin_s2[P_CS] && cmd == CMD_REFRESH) ? PWR_RENEW : PWR_LOW;
          end
        end
        PWR_LOW, PWR_RENEW: begin
          if (q.pin_s2[P_CKE]) begin
            n.pwr = PWR_ACTIVE;
          end
        end
        default: begin
          n.pwr = PWR_ACTIVE;
        end
      endcase
    end

    // undefined codes fall to default and are ignored
    if (cmd_take) begin
      case (cmd)
        CMD_ROW_OPEN: begin
          // per-bank flags let banks open and close independently
          n.bank_open[cmd_ba] = 1'b1;
          n.open_row[cmd_ba] = cmd_a[ROW_MSB:0];
        end
        CMD_CLOSE: begin
          if (cmd_a[AP_BIT]) begin
            n.bank_open = '0;
          end else begin
            n.bank_open[cmd_ba] = 1'b0;
          end
        end
        CMD_MODE: begin
          if (cmd_ba == MR0_BANK) begin
            n.mr_bl = cmd_a[MR_BL_MSB:0];
            n.mr_interleave = cmd_a[MR_BT_BIT];
          end
        end
        CMD_READ: begin
          // closed bank or busy engine: command dropped
          if (q.bank_open[cmd_ba] && q.rd == RD_IDLE && !q.fetch_busy) begin
            n.fetch_busy = 1'b1;
            n.fetch_bank = cmd_ba;
            n.fetch_hi = {q.open_row[cmd_ba][0], cmd_a[COL_HI_BIT]};
            n.fetch_start = cmd_a[ORD_MSB:0];
            n.fetch_idx = 4'h0;
            n.fetch_len = burst_len(q.mr_bl, cmd_a[BC_BIT]);
            n.rd = RD_WAIT;
            n.rd_lat = RD_WAIT_INIT;
            n.rd_autoclose = cmd_a[AP_BIT];
            n.rd_bank = cmd_ba;
          end
        end
        CMD_WRITE: begin
          if (q.bank_open[cmd_ba] && !q.wr_armed) begin
            n.wr_armed = 1'b1;
            n.wr_bank = cmd_ba;
            n.wr_hi = {q.open_row[cmd_ba][0], cmd_a[COL_HI_BIT]};
            n.wr_start = cmd_a[ORD_MSB:0];
            n.wr_idx = 4'h0;
            n.wr_len = burst_len(q.mr_bl, cmd_a[BC_BIT]);
            n.wr_autoclose = cmd_a[AP_BIT];
          end
        end
        default: begin
          n.wr_armed = q.wr_armed;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.pwr <= PWR_ACTIVE;
      q.rd <= RD_IDLE;
      q.dqs_c <= 1'b1;
    end else if (clk_en_in) begin
      q <= n;
    end
  end

  assign dq_out = q.dq_o;
  assign dq_oe_out = q.dq_oe;
  assign dqs_true_out = q.dqs_o;
  assign dqs_comp_out = q.dqs_c;
  assign dqs_oe_out = q.dqs_oe;

  chk_mode_on_rise: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    !ck_rise |=> $stable(q.mr_bl) && $stable(q.mr_interleave))
    else $error("mode changed without clock rise");

  chk_row_open_latch: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (cmd_take && cmd == CMD_ROW_OPEN) |=>
      q.bank_open[$past(cmd_ba)] && q.open_row[$past(cmd_ba)] == $past(cmd_a))
    else $error("row open did not latch bank and row");

  chk_read_len: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.rd == RD_DATA && ck_edge && q.rd_left == 4'h0) |->
      !pop_valid && !q.fetch_busy && (q.fetch_len == BEATS_FULL || q.fetch_len == BEATS_CHOP))
    else $error("burst did not move exactly eight or four beats");

  chk_read_preamble: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.rd == RD_PRE) |-> q.dqs_oe && !q.dqs_o && !q.dq_oe && pop_valid)
    else $error("read preamble wrong or no data ready");

  chk_read_edge: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.rd == RD_DATA && ck_edge && q.rd_left != 4'h0) |=>
      q.dqs_o != $past(q.dqs_o) && q.dqs_c == $past(q.dqs_o))
    else $error("read strobe did not toggle with beat");

  chk_write_first: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.wr_armed && q.wr_idx == 4'h0 && dqs_edge && !dqs_rise) |=> q.wr_idx == 4'h0)
    else $error("write beat taken on strobe fall");

  chk_auto_close: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.rd == RD_DATA && ck_edge && q.rd_left == 4'h0 && q.rd_autoclose &&
     !(cmd_take && cmd == CMD_ROW_OPEN)) |=> !q.bank_open[$past(q.rd_bank)])
    else $error("auto close left row open");

  chk_quiet_bus: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.rd == RD_IDLE || q.rd == RD_WAIT) |-> !q.dq_oe && !q.dqs_oe)
    else $error("pins driven outside read");

  chk_power_hold: assert property (@(posedge clock_in) disable iff (rst_in || !clk_en_in)
    (q.pwr != PWR_ACTIVE && !ck_rise) |=> q.pwr == $past(q.pwr))
    else $error("power state left without clock rise");
endmodule // ddr_access_core

// file: verification/ddr_ctl_model.sv
// behavioural memory controller: link clock, command pins and data/strobe wires
`timescale 1ns/1ns
module ddr_ctl_model (
  input wire logic clock_in,
  output logic ck_t_out,
  output logic ck_c_out,
  output logic cke_out,
  output logic cs_n_out,
  output logic [2:0] cmd_out,
  output logic [ddr_core_pkg::BANK_W-1:0] ba_out,
  output logic [ddr_core_pkg::ADDR_W-1:0] addr_out,
  output logic dm_out,
  output logic [ddr_core_pkg::DQ_W-1:0] dq_wire_out,
  output logic dqs_t_wire_out,
  output logic dqs_c_wire_out,
  input wire logic [ddr_core_pkg::DQ_W-1:0] dq_in,
  input wire logic dq_oe_in,
  input wire logic dqs_t_in,
  input wire logic dqs_c_in,
  input wire logic dqs_oe_in
);
  import ddr_core_pkg::*;
  logic [2:0] ph_reg = 3'h0;
  logic m_oe = 1'b0;
  logic m_dqs = 1'b0;
  logic dqs_last = 1'b0;
  logic dqs_keep = 1'b0;
  logic [7:0] m_dq = 8'h00;
  logic [7:0] dq_keep = 8'h00;
  logic [7:0] beats [$];
  int bad_drive = 0;
  initial begin
    ck_t_out = 1'b0;
    cke_out = 1'b1;
    cs_n_out = 1'b1;
    cmd_out = 3'h7;
    ba_out = 3'h0;
    addr_out = 14'h0000;
    dm_out = 1'b0;
  end
  // no pull on these wires: once released they show the inverse of the last level
  assign dq_wire_out = dq_oe_in ? dq_in : m_oe ? m_dq : ~dq_keep;
  assign dqs_t_wire_out = dqs_oe_in ? dqs_t_in : m_oe ? m_dqs : ~dqs_keep;
  assign dqs_c_wire_out = dqs_oe_in ? dqs_c_in : m_oe ? ~m_dqs : dqs_keep;
  assign ck_c_out = ~ck_t_out;
  always @(posedge clock_in) begin
    ph_reg <= ph_reg + 3'h1;
    ck_t_out <= (ph_reg >= 3'h3) && (ph_reg != 3'h7);
    if (dq_oe_in | dqs_oe_in | m_oe) begin
      dq_keep <= dq_wire_out;
      dqs_keep <= dqs_t_wire_out;
    end
    dqs_last <= dqs_t_in;
    if (dq_oe_in && (dqs_t_in != dqs_last))
      beats.push_back(dq_in);
    if (dq_oe_in && !dqs_oe_in)
      bad_drive++;
    // strobe pair must stay complementary while driven
    if (dqs_oe_in && (dqs_c_in == dqs_t_in))
      bad_drive++;
  end
  task automatic at_fall();
    do @(posedge clock_in); while (ph_reg != 3'h7);
  endtask
  // pins change at a link fall, so they stand four clocks either side of the rise
  task automatic cmd(input logic cke, input logic cs_n, input logic [2:0] code,
                     input logic [2:0] ba, input logic [13:0] addr);
    at_fall();
    cke_out <= cke;
    cs_n_out <= cs_n;
    cmd_out <= code;
    ba_out <= ba;
    addr_out <= addr;
    at_fall();
    cs_n_out <= 1'b1;
    cmd_out <= 3'h7;
  endtask
  // caller opens the row first lower lane only on this width
  task automatic wr(input logic [2:0] ba, input logic [13:0] addr, input logic [7:0] d [8],
                    input logic [7:0] mask, input int n);
    cmd(1'b1, 1'b0, CMD_WRITE, ba, addr);
    m_dqs <= 1'b0;
    m_oe <= 1'b1;
    repeat (8) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      m_dq <= d[i];
      dm_out <= mask[i];
      repeat (2) @(posedge clock_in);
      m_dqs <= ~m_dqs;
      repeat (2) @(posedge clock_in);
    end
    repeat (2) @(posedge clock_in);
    m_oe <= 1'b0;
    dm_out <= 1'b0;
  endtask
endmodule // ddr_ctl_model

// file: verification/testbench.sv
// top bench: clock, reset, access core, controller model and scenarios
`timescale 1ns/1ns
module testbench;
  import ddr_core_pkg::*;
  localparam logic [13:0] ROW = 14'h0004;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en = 1'b1;
  logic ck_t, ck_c, cke, cs_n, dm, dq_oe, dqs_t, dqs_c, dqs_oe, dqs_tw, dqs_cw;
  logic [2:0] cmd, ba;
  logic [13:0] addr;
  logic [7:0] dq, dqw;
  logic [7:0] pat [8];
  logic [7:0] img2 [8];
  logic [7:0] img5 [8];
  logic [7:0] exp_q [$];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #20 clock_in = ~clock_in;
  ddr_access_core u_dut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .diff_clock_true_in(ck_t), .diff_clock_comp_in(ck_c), .cke_in(cke), .cs_n_in(cs_n),
    .ras_n_in(cmd[2]), .cas_n_in(cmd[1]), .we_n_in(cmd[0]), .ba_in(ba), .addr_in(addr),
    .dm_in(dm), .dq_in(dqw), .dq_out(dq), .dq_oe_out(dq_oe), .dqs_true_in(dqs_tw),
    .dqs_comp_in(dqs_cw), .dqs_true_out(dqs_t), .dqs_comp_out(dqs_c), .dqs_oe_out(dqs_oe));
  ddr_ctl_model u_ctl (.clock_in(clock_in), .ck_t_out(ck_t), .ck_c_out(ck_c), .cke_out(cke),
    .cs_n_out(cs_n), .cmd_out(cmd), .ba_out(ba), .addr_out(addr), .dm_out(dm),
    .dq_wire_out(dqw), .dqs_t_wire_out(dqs_tw), .dqs_c_wire_out(dqs_cw), .dq_in(dq),
    .dq_oe_in(dq_oe), .dqs_t_in(dqs_t), .dqs_c_in(dqs_c), .dqs_oe_in(dqs_oe));
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // column walk: sequential wraps the low two bits and xors the top bit with index bit 2, interleaved xors the index
  function automatic void expect_burst(input logic [7:0] img [8], input logic [2:0] s,
                                       input int n, input logic il);
    logic [2:0] k;
    for (int i = 0; i < n; i++) begin
      k = 3'(i);
      exp_q.push_back(img[il ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]}]);
    end
  endfunction
  // fixed wait covers read latency, burst and postamble before the next read
  task automatic rd(input logic cke_v, input logic [2:0] b, input logic [13:0] a);
    u_ctl.beats.delete();
    u_ctl.cmd(cke_v, 1'b0, CMD_READ, b, a);
    repeat (110) @(posedge clock_in);
    check(8'(u_ctl.beats.size()), 8'(exp_q.size()));
    foreach (exp_q[i])
      check(u_ctl.beats[i], exp_q[i]);
    check({6'h00, dq_oe, dqs_oe}, 8'h00);
    exp_q.delete();
  endtask
  task automatic t_write_read();
    for (int i = 0; i < 8; i++) begin
      pat[i] = 8'hA0 + 8'(i);
      img2[i] = (i == 6) ? 8'h00 : pat[i];
      img5[i] = (i < 4) ? 8'hB0 + 8'(i) : 8'h00;
    end
    check({6'h00, dq_oe, dqs_oe}, 8'h00);
    u_ctl.cmd(1'b1, 1'b0, CMD_MODE, MR0_BANK, 14'h0001);
    u_ctl.cmd(1'b1, 1'b0, CMD_ROW_OPEN, 3'h2, ROW);
    u_ctl.wr(3'h2, 14'h1000, pat, 8'h40, 8);
    expect_burst(img2, 3'h0, 8, 1'b0);
    rd(1'b1, 3'h2, 14'h1000);
  endtask
  task automatic t_order();
    expect_burst(img2, 3'h5, 4, 1'b0);
    rd(1'b1, 3'h2, 14'h0005);
    u_ctl.cmd(1'b1, 1'b0, CMD_MODE, MR0_BANK, 14'h0009);
    expect_burst(img2, 3'h3, 8, 1'b1);
    rd(1'b1, 3'h2, 14'h1003);
    u_ctl.cmd(1'b1, 1'b0, CMD_MODE, MR0_BANK, 14'h0002);
    expect_burst(img2, 3'h0, 4, 1'b0);
    rd(1'b1, 3'h2, 14'h1000); // fixed four ignores the chop bit
    u_ctl.cmd(1'b1, 1'b0, CMD_MODE, MR0_BANK, 14'h0000);
    expect_burst(img2, 3'h0, 8, 1'b0);
    rd(1'b1, 3'h2, 14'h0000);
    u_ctl.cmd(1'b1, 1'b0, CMD_MODE, MR0_BANK, 14'h0001);
  endtask
  task automatic t_banks();
    u_ctl.cmd(1'b1, 1'b0, CMD_ROW_OPEN, 3'h5, ROW);
    u_ctl.wr(3'h5, 14'h0000, img5, 8'h00, 4);
    expect_burst(img2, 3'h0, 8, 1'b0);
    rd(1'b1, 3'h2, 14'h1000);
    expect_burst(img5, 3'h0, 4, 1'b0);
    rd(1'b1, 3'h5, 14'h0400);
    rd(1'b1, 3'h5, 14'h0000); // row already shut, no burst
    u_ctl.cmd(1'b1, 1'b0, CMD_ROW_OPEN, 3'h5, ROW);
    expect_burst(img5, 3'h0, 4, 1'b0);
    rd(1'b1, 3'h5, 14'h0000);
  endtask
  // a row open sent while asleep must be lost, so the read after wake is refused
  // bench stays in the normal temperature range, so no doubled refresh rate
  task automatic t_power();
    for (int k = 0; k < 2; k++) begin
      u_ctl.cmd(1'b1, 1'b0, CMD_CLOSE, 3'h0, 14'h0400);
      u_ctl.cmd(1'b0, k == 0, (k != 0) ? CMD_REFRESH : 3'h7, 3'h0, 14'h0000);
      u_ctl.cmd(1'b0, 1'b0, CMD_ROW_OPEN, 3'h2, ROW);
      u_ctl.cmd(1'b1, 1'b1, 3'h7, 3'h0, 14'h0000);
      rd(1'b1, 3'h2, 14'h1000);
      u_ctl.cmd(1'b1, 1'b0, CMD_ROW_OPEN, 3'h2, ROW);
      expect_burst(img2, 3'h0, 8, 1'b0);
      rd(1'b1, 3'h2, 14'h1000);
    end
  endtask
  // a core frozen by its enable misses a whole row open, so the next read is refused
  task automatic t_freeze();
    u_ctl.cmd(1'b1, 1'b0, CMD_CLOSE, 3'h0, 14'h0400);
    clk_en <= 1'b0;
    u_ctl.cmd(1'b1, 1'b0, CMD_ROW_OPEN, 3'h2, ROW);
    clk_en <= 1'b1;
    rd(1'b1, 3'h2, 14'h1000);
    u_ctl.cmd(1'b1, 1'b0, CMD_ROW_OPEN, 3'h2, ROW);
    expect_burst(img2, 3'h0, 8, 1'b0);
    rd(1'b1, 3'h2, 14'h1000);
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    // two spare link periods let the synced cke settle high
    repeat (16) @(posedge clock_in);
    t_write_read();
    t_order();
    t_banks();
    t_power();
    t_freeze();
    check(8'(u_ctl.bad_drive), 8'h00);
    report_and_stop();
  end
endmodule // testbench
